// ==== design/spsi_pkg.sv ====
// package of the serial port status and interrupt block
// assumes a 10 MHz core clock and an AXI4-Lite register slave with 32-bit data
package spsi_pkg;

  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam logic [3:0] STATUS_OFFSET = 4'h0;  // serial_status_flags
  localparam logic [3:0] CONTROL_OFFSET = 4'h4;  // serial_control_reg
  localparam logic [3:0] TX_HOLD_OFFSET = 4'h8;  // tx_holding_reg
  localparam logic [3:0] RX_HOLD_OFFSET = 4'hc;  // rx_holding_reg, read only

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int RX_FULL_BIT = 0;
  localparam int TX_EMPTY_BIT = 1;
  localparam int RX_OVERRUN_BIT = 2;
  localparam int TX_UNDERRUN_BIT = 3;
  localparam int FLAG_WIDTH = 4;
  localparam int RX_ENABLE_BIT = 0;
  localparam int TX_ENABLE_BIT = 1;
  localparam int RX_IRQ_ENABLE_BIT = 2;
  localparam int TX_IRQ_ENABLE_BIT = 3;
  localparam logic [15:0] STATUS_RESET = 16'h0002;
  localparam logic [3:0] CONTROL_RESET = 4'h0;
  localparam logic [15:0] HOLD_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // highest pending request code
  // ************************************************************
  typedef enum logic [2:0]
  {
    SPSI_IRQ_NONE = 3'h0,
    SPSI_IRQ_RX_OVERRUN = 3'h1,
    SPSI_IRQ_TX_UNDERRUN = 3'h2,
    SPSI_IRQ_RX_FULL = 3'h3,
    SPSI_IRQ_TX_EMPTY = 3'h4
  } spsi_irq_code_t;

  // ************************************************************
  // whole module state
  // ************************************************************
  typedef struct packed {
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] control;
    logic [3:0] flags;
    logic [3:0] armed;
    logic [15:0] tx_hold;
    logic [15:0] rx_hold;
    logic [1:0] tx_sync;
    logic tx_prev;
    logic [1:0] rx_sync;
    logic rx_prev;
  } spsi_state_t;

endpackage : spsi_pkg

// ==== design/spsi_top.sv ====
// status flags, request lines and register slave of one serial channel
// assumes link frame levels arrive unsynchronised; dma strobes are on core clock
//
// What this block does
// - status register is 16 bits and resets to 0x0002, only tx empty set.
// - status bits 15 to 4 read zero; software writes zero there.
// - transmission start while tx enable and tx empty set raises tx underrun flag, bit 3.
// - tx underrun clears by zero written after reading one, or by reset.
// - reception end while rx enable and rx full set raises rx overrun flag, bit 2.
// - rx overrun clears by zero written after reading one, or by reset.
// - tx empty, bit 1, clears by zero written after reading one.
// - dma write of tx holding register clears tx empty.
// - tx empty sets on load into shift register, tx enable low, reset.
// - rx full, bit 0, sets when a finished word enters rx holding register.
// - rx full clears on dma read, read-one-write-zero, rx enable low, reset.
// - four separate requests: rx overrun, tx underrun, rx full, tx empty.
// - rx full request gated by rx irq enable, tx empty by tx irq enable.
// - overrun and underrun requests have no enable gating.
// - rx full request asserted whenever rx full flag and rx irq enable set; may start dma.
// - tx empty request asserted whenever tx empty flag and tx irq enable set; may start dma.
// - rx overrun request follows rx overrun flag.
// - tx underrun request follows tx underrun flag.
// - priority: overrun, underrun, rx full, tx empty; only data requests reach dma.
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps

module spsi_top
(
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  // axi4-lite write address and data
  input wire logic [31:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // axi4-lite read
  input wire logic [31:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // link side frame levels and words
  input wire logic TX_BUSY_I,
  input wire logic RX_BUSY_I,
  input wire logic [15:0] RX_WORD_I,
  output logic [15:0] TX_WORD_O,
  // dma strobes
  input wire logic DMA_TX_WRITE_I,
  input wire logic [15:0] DMA_TX_DATA_I,
  input wire logic DMA_RX_READ_I,
  output logic [15:0] RX_DATA_O,
  // request lines
  output logic RX_OVERRUN_IRQ_O,
  output logic TX_UNDERRUN_IRQ_O,
  output logic RX_FULL_IRQ_O,
  output logic TX_EMPTY_IRQ_O,
  output logic DMA_RX_REQ_O,
  output logic DMA_TX_REQ_O,
  output logic [2:0] IRQ_CODE_O
);

  // ************************************************************
  // helpers
  // ************************************************************

  // highest pending request, fixed priority
  function automatic spsi_pkg::spsi_irq_code_t top_request(input logic [3:0] req);
    spsi_pkg::spsi_irq_code_t code;
    code = spsi_pkg::SPSI_IRQ_NONE;
    if (req[spsi_pkg::RX_OVERRUN_BIT])
      code = spsi_pkg::SPSI_IRQ_RX_OVERRUN;
    else if (req[spsi_pkg::TX_UNDERRUN_BIT])
      code = spsi_pkg::SPSI_IRQ_TX_UNDERRUN;
    else if (req[spsi_pkg::RX_FULL_BIT])
      code = spsi_pkg::SPSI_IRQ_RX_FULL;
    else if (req[spsi_pkg::TX_EMPTY_BIT])
      code = spsi_pkg::SPSI_IRQ_TX_EMPTY;
    return code;
  endfunction : top_request

  // word index of a mapped register, or all ones when unmapped
  function automatic logic [2:0] reg_index(input logic [31:0] addr);
    logic [2:0] idx;
    idx = 3'h7;
    if (addr[31:4] == 28'h0000000)
    begin
      case (addr[3:0])
        spsi_pkg::STATUS_OFFSET: idx = 3'h0;
        spsi_pkg::CONTROL_OFFSET: idx = 3'h1;
        spsi_pkg::TX_HOLD_OFFSET: idx = 3'h2;
        spsi_pkg::RX_HOLD_OFFSET: idx = 3'h3;
        default: idx = 3'h7;
      endcase
    end
    return idx;
  endfunction : reg_index

  // ************************************************************
  // state
  // ************************************************************
  spsi_pkg::spsi_state_t st;
  spsi_pkg::spsi_state_t next_st;
  logic tx_start;
  logic rx_end;
  logic [3:0] req;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic do_write;
  logic do_read;

  // frame edges, seen only on the second sync flop and its delayed copy
  assign tx_start = st.tx_sync[1] & ~st.tx_prev;
  assign rx_end = ~st.rx_sync[1] & st.rx_prev;
  assign wr_idx = reg_index({28'h0000000, st.aw_addr});
  assign rd_idx = reg_index(S_AXI_ARADDR_I);
  assign do_write = st.aw_held & st.w_held & ~st.bvalid;
  assign do_read = S_AXI_ARVALID_I & ~st.rvalid;

  // request lines straight off the flag flops
  assign req[spsi_pkg::RX_OVERRUN_BIT] = st.flags[spsi_pkg::RX_OVERRUN_BIT];
  assign req[spsi_pkg::TX_UNDERRUN_BIT] = st.flags[spsi_pkg::TX_UNDERRUN_BIT];
  assign req[spsi_pkg::RX_FULL_BIT] = st.flags[spsi_pkg::RX_FULL_BIT]
    & st.control[spsi_pkg::RX_IRQ_ENABLE_BIT];
  assign req[spsi_pkg::TX_EMPTY_BIT] = st.flags[spsi_pkg::TX_EMPTY_BIT]
    & st.control[spsi_pkg::TX_IRQ_ENABLE_BIT];

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    logic [3:0] sw_clr;
    logic [3:0] rd_flags;
    next_st = st;
    sw_clr = 4'h0;
    rd_flags = st.flags;

    // synchronisers and edge history
    next_st.tx_sync = {st.tx_sync[0], TX_BUSY_I};
    next_st.tx_prev = st.tx_sync[1];
    next_st.rx_sync = {st.rx_sync[0], RX_BUSY_I};
    next_st.rx_prev = st.rx_sync[1];

    // write address and data are taken independently, in either order
    if (S_AXI_AWVALID_I & ~st.aw_held & ~st.bvalid)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = S_AXI_AWADDR_I[3:0];
      if (S_AXI_AWADDR_I[31:4] != 28'h0000000)
        next_st.aw_addr = 4'h1;  // misaligned marker, decodes as unmapped
    end
    if (S_AXI_WVALID_I & ~st.w_held & ~st.bvalid)
    begin
      next_st.w_held = 1'b1;
      next_st.w_data = S_AXI_WDATA_I;
      next_st.w_strb = S_AXI_WSTRB_I;
    end

    // perform the write once both halves are held
    if (do_write)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = spsi_pkg::RESP_OKAY;
      case (wr_idx)
        3'h0:
        begin
          // zero clears only a bit that was read as one; a one is ignored
          if (st.w_strb[0])
            sw_clr = st.armed & ~st.w_data[3:0];
        end
        3'h1:
        begin
          if (st.w_strb[0])
            next_st.control = st.w_data[3:0];
        end
        3'h2:
        begin
          if (st.w_strb[0])
            next_st.tx_hold[7:0] = st.w_data[7:0];
          if (st.w_strb[1])
            next_st.tx_hold[15:8] = st.w_data[15:8];
        end
        default: next_st.bresp = spsi_pkg::RESP_SLVERR;
      endcase
    end
    if (st.bvalid & S_AXI_BREADY_I)
      next_st.bvalid = 1'b0;

    // read answers one cycle after the address is taken
    if (do_read)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = spsi_pkg::RESP_OKAY;
      next_st.rdata = 32'h00000000;
      case (rd_idx)
        3'h0: next_st.rdata = {28'h0000000, rd_flags};
        3'h1: next_st.rdata = {28'h0000000, st.control};
        3'h2: next_st.rdata = {16'h0000, st.tx_hold};
        3'h3: next_st.rdata = {16'h0000, st.rx_hold};
        default: next_st.rresp = spsi_pkg::RESP_SLVERR;
      endcase
    end
    if (st.rvalid & S_AXI_RREADY_I)
      next_st.rvalid = 1'b0;

    // dma write replaces the holding word; cpu writes to the holding word never clear the flag
    if (DMA_TX_WRITE_I)
      next_st.tx_hold = DMA_TX_DATA_I;

    // clears first, so any set below overrides them
    next_st.flags = st.flags & ~sw_clr;
    next_st.armed = st.armed & ~sw_clr;
    if (DMA_TX_WRITE_I)
      next_st.flags[spsi_pkg::TX_EMPTY_BIT] = 1'b0;
    if (DMA_RX_READ_I | ~st.control[spsi_pkg::RX_ENABLE_BIT])
      next_st.flags[spsi_pkg::RX_FULL_BIT] = 1'b0;

    // transmission start: underrun if nothing was loaded, else load
    if (tx_start & st.control[spsi_pkg::TX_ENABLE_BIT])
    begin
      if (st.flags[spsi_pkg::TX_EMPTY_BIT])
        next_st.flags[spsi_pkg::TX_UNDERRUN_BIT] = 1'b1;
      next_st.flags[spsi_pkg::TX_EMPTY_BIT] = 1'b1;
    end
    // transmit disabled holds the holding register empty
    if (~st.control[spsi_pkg::TX_ENABLE_BIT])
      next_st.flags[spsi_pkg::TX_EMPTY_BIT] = 1'b1;

    // reception end: word always lands, overrun if the old one waited
    if (rx_end & st.control[spsi_pkg::RX_ENABLE_BIT])
    begin
      if (st.flags[spsi_pkg::RX_FULL_BIT])
        next_st.flags[spsi_pkg::RX_OVERRUN_BIT] = 1'b1;
      next_st.flags[spsi_pkg::RX_FULL_BIT] = 1'b1;
      next_st.rx_hold = RX_WORD_I;
    end

    // a status read arms the clear for every bit seen as one
    if (do_read & (rd_idx == 3'h0))
      next_st.armed = next_st.armed | rd_flags;
    // a bit that is now zero cannot stay armed
    next_st.armed = next_st.armed & next_st.flags;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!NRST_I)
    begin
      st <= '0;
      st.control <= spsi_pkg::CONTROL_RESET;
      st.flags <= spsi_pkg::STATUS_RESET[3:0];
      st.tx_hold <= spsi_pkg::HOLD_RESET;
      st.rx_hold <= spsi_pkg::HOLD_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign S_AXI_AWREADY_O = ~st.aw_held & ~st.bvalid;
  assign S_AXI_WREADY_O = ~st.w_held & ~st.bvalid;
  assign S_AXI_BVALID_O = st.bvalid;
  assign S_AXI_BRESP_O = st.bresp;
  assign S_AXI_ARREADY_O = ~st.rvalid;
  assign S_AXI_RVALID_O = st.rvalid;
  assign S_AXI_RDATA_O = st.rdata;
  assign S_AXI_RRESP_O = st.rresp;
  assign TX_WORD_O = st.tx_hold;
  assign RX_DATA_O = st.rx_hold;
  // four separate lines; dma sees only the data requests
  assign RX_OVERRUN_IRQ_O = req[spsi_pkg::RX_OVERRUN_BIT];
  assign TX_UNDERRUN_IRQ_O = req[spsi_pkg::TX_UNDERRUN_BIT];
  assign RX_FULL_IRQ_O = req[spsi_pkg::RX_FULL_BIT];
  assign TX_EMPTY_IRQ_O = req[spsi_pkg::TX_EMPTY_BIT];
  assign DMA_RX_REQ_O = req[spsi_pkg::RX_FULL_BIT];
  assign DMA_TX_REQ_O = req[spsi_pkg::TX_EMPTY_BIT];
  assign IRQ_CODE_O = top_request(req);

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  reset_value_a: assert property ($rose(NRST_I) |-> st.flags == 4'h2)
    else $error("status not 0x0002 after reset");
  reserved_zero_a: assert property (st.rvalid && $past(rd_idx) == 3'h0 && $past(do_read)
    |-> st.rdata[31:4] == 28'h0)
    else $error("reserved status bits not zero");
  underrun_set_a: assert property (tx_start && st.control[1] && st.flags[1]
    |=> st.flags[3])
    else $error("underrun not flagged");
  overrun_set_a: assert property (rx_end && st.control[0] && st.flags[0]
    |=> st.flags[2] && st.rx_hold == $past(RX_WORD_I))
    else $error("overrun not flagged");
  no_one_set_a: assert property (!tx_start && !rx_end && !st.flags[3] && !st.flags[2]
    |=> !st.flags[3] && !st.flags[2])
    else $error("error flag set without cause");
  dma_clear_a: assert property (DMA_TX_WRITE_I && st.control[1] && !tx_start
    |=> !st.flags[1])
    else $error("dma write left tx empty set");
  tx_off_empty_a: assert property (!st.control[1] |=> st.flags[1])
    else $error("tx empty low while tx disabled");
  rx_off_clear_a: assert property (!st.control[0] |=> !st.flags[0])
    else $error("rx full set while rx disabled");
  gate_rx_a: assert property (RX_FULL_IRQ_O == (st.flags[0] && st.control[2]))
    else $error("rx full request gating wrong");
  priority_a: assert property (st.flags[2] |-> IRQ_CODE_O == 3'h1 && RX_OVERRUN_IRQ_O)
    else $error("overrun not top priority");
  set_wins_a: assert property (tx_start && st.control[1] |=> st.flags[1])
    else $error("clear beat a set of tx empty");
  read_latency_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("read answer not one cycle later");
  // one write at a time: both readies stay low while the answer waits
  write_single_a: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write taken while answer pending");

  // an unarmed error or tx empty flag survives any bus write; only a prior read arms the clear
  underrun_hold_a: assert property (st.flags[3] && !st.armed[3]
    |=> st.flags[3])
    else $error("underrun cleared without a prior read");
  overrun_hold_a: assert property (st.flags[2] && !st.armed[2]
    |=> st.flags[2])
    else $error("overrun cleared without a prior read");
  empty_hold_a: assert property (st.flags[1] && !st.armed[1] && !DMA_TX_WRITE_I
    |=> st.flags[1])
    else $error("tx empty cleared without read or dma");

  // receive side: word lands with the flag, dma read empties it
  rx_full_set_a: assert property (rx_end && st.control[0]
    |=> st.flags[0] && st.rx_hold == $past(RX_WORD_I))
    else $error("rx full not set at reception end");
  dma_rx_clear_a: assert property (DMA_RX_READ_I && !rx_end
    |=> !st.flags[0])
    else $error("dma read left rx full set");

  // request lines; error lines ignore the enables so no fault is hidden
  gate_tx_a: assert property (TX_EMPTY_IRQ_O == (st.flags[1] && st.control[3]))
    else $error("tx empty request gating wrong");
  error_lines_a: assert property ((RX_OVERRUN_IRQ_O == st.flags[2])
    && (TX_UNDERRUN_IRQ_O == st.flags[3]))
    else $error("error request not equal to its flag");
  dma_lines_a: assert property ((DMA_RX_REQ_O == RX_FULL_IRQ_O)
    && (DMA_TX_REQ_O == TX_EMPTY_IRQ_O))
    else $error("dma request differs from data request");
  underrun_rank_a: assert property (!st.flags[2] && st.flags[3] |-> IRQ_CODE_O == 3'h2)
    else $error("underrun not second in priority");
  // enables reset low, so nothing may be requested right after reset
  reset_quiet_a: assert property ($rose(NRST_I) |-> IRQ_CODE_O == 3'h0 && !TX_EMPTY_IRQ_O)
    else $error("request pending right after reset");

endmodule : spsi_top

// ==== dv/spsi_link_model.sv ====
// link side model: frame levels and received words of one serial channel
// assumes the bench calls its tasks; its clock runs only while a frame task runs
`timescale 1ns/1ps

module spsi_link_model
(
  // frame levels and word toward the channel
  output logic tx_busy_o,
  output logic rx_busy_o,
  output logic [15:0] rx_word_o
);
  logic link_clk;

  // ************************************************************
  // idle levels
  // ************************************************************
  initial
  begin
    tx_busy_o = 1'b0;
    rx_busy_o = 1'b0;
    rx_word_o = 16'h0000;
    link_clk = 1'b0;
  end

  // ************************************************************
  // frame timing
  // ************************************************************
  // 800 ns link clock, stands still between frames
  task automatic tick(input int n);
    repeat (2 * n)
    begin
      #400 link_clk = ~link_clk;
    end
  endtask : tick

  // odd offset keeps link edges unrelated to core edges
  task automatic tx_frame();
    #137 tx_busy_o = 1'b1;
    tick(4);
    tx_busy_o = 1'b0;
  endtask : tx_frame

  // word held a full link period past the end of frame, then spoilt
  task automatic rx_frame(input logic [15:0] w);
    #137 rx_busy_o = 1'b1;
    tick(3);
    rx_word_o = w;
    tick(1);
    rx_busy_o = 1'b0;
    tick(1);
    rx_word_o = ~w;
  endtask : rx_frame
endmodule : spsi_link_model

// ==== dv/spsi_top_test.sv ====
// self-checking bench of the serial status and request block
// assumes the link model is compiled first; 10 MHz core clock
`timescale 1ns/1ps

module spsi_top_test;
  localparam logic [1:0] OK = spsi_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = spsi_pkg::RESP_SLVERR;
  localparam logic [31:0] A_ST = {28'h0000000, spsi_pkg::STATUS_OFFSET};
  localparam logic [31:0] A_CT = {28'h0000000, spsi_pkg::CONTROL_OFFSET};
  localparam logic [31:0] A_RX = {28'h0000000, spsi_pkg::RX_HOLD_OFFSET};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic dma_wr = 1'b0, dma_rd = 1'b0;
  logic [15:0] dma_data = 16'h0, tx_word, rx_data, rx_word;
  logic awready, wready, bvalid, arready, rvalid, tx_busy, rx_busy;
  logic [1:0] bresp, rresp;
  logic rxo, txu, rxf, txe, drx, dtx;
  logic [2:0] code;
  logic [8:0] irqv;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int err_total = 0, tests_run = 0, cycles = 0;

  assign irqv = {rxo, txu, rxf, txe, drx, dtx, code};

  // ************************************************************
  // clock, design and link model
  // ************************************************************
  always #50 clk = ~clk;

  spsi_top spsi_top_inst (.CORE_CLK_I(clk), .NRST_I(nrst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .TX_BUSY_I(tx_busy), .RX_BUSY_I(rx_busy), .RX_WORD_I(rx_word), .TX_WORD_O(tx_word),
    .DMA_TX_WRITE_I(dma_wr), .DMA_TX_DATA_I(dma_data), .DMA_RX_READ_I(dma_rd), .RX_DATA_O(rx_data),
    .RX_OVERRUN_IRQ_O(rxo), .TX_UNDERRUN_IRQ_O(txu), .RX_FULL_IRQ_O(rxf), .TX_EMPTY_IRQ_O(txe),
    .DMA_RX_REQ_O(drx), .DMA_TX_REQ_O(dtx), .IRQ_CODE_O(code));

  spsi_link_model spsi_link_model_inst (.tx_busy_o(tx_busy), .rx_busy_o(rx_busy), .rx_word_o(rx_word));

  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // watcher takes the oldest note at each bus answer
  always @(posedge clk)
  begin
    if (bvalid && bready)
      chk({14'h0, bresp}, {14'h0, bq.pop_front()});
    if (rvalid && rready)
    begin
      tests_run++;
      if ({rresp, rdata} !== rq.pop_front())
      begin
        err_total++;
        $display("Error at %0t: read answer %h %h", $time, rresp, rdata);
      end
    end
  end

  // hang guard, run needs well under 2000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      final_report();
    end
  end

  // ************************************************************
  // bus master and strobes
  // ************************************************************
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // each channel released at its own handshake edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    logic pa, pw, pb;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw || pb)
    begin
      @(posedge clk);
      if (pb && bvalid)
      begin
        bready <= 1'b0;
        pb = 1'b0;
      end
      if (pa && awready)
      begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wready)
      begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    // one free edge, so a following call never re-drives bready in this step
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    logic pa, pr;
    pa = 1'b1;
    pr = 1'b1;
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (pa || pr)
    begin
      @(posedge clk);
      if (pr && rvalid)
      begin
        rready <= 1'b0;
        pr = 1'b0;
      end
      if (pa && arready)
      begin
        arvalid <= 1'b0;
        pa = 1'b0;
      end
    end
    // one free edge, so a following call never re-drives rready in this step
    @(posedge clk);
  endtask : rd

  // one-cycle dma strobe, write or read
  task automatic dma(input logic w, input logic [15:0] d);
    dma_wr <= w;
    dma_rd <= !w;
    dma_data <= d;
    @(posedge clk);
    dma_wr <= 1'b0;
    dma_rd <= 1'b0;
    idle(2);
  endtask : dma

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    logic [15:0] d, w1, w2;
    void'($urandom(32'h2d263a09));
    d = 16'($urandom);
    w1 = 16'($urandom);
    w2 = 16'($urandom);
    idle(12);
    nrst <= 1'b1;
    @(posedge clk);
    rd(A_ST, 32'h2, OK);
    chk({7'h00, irqv}, 16'h0000);
    wr(32'h10, 32'h1, ERR);
    rd(32'h10, 32'h0, ERR);
    wr(A_RX, 32'h1, ERR);
    wr(A_ST, 32'h0000000f, OK);
    rd(A_ST, 32'h2, OK);
    wr(A_CT, 32'hf, OK);
    chk({7'h00, irqv}, 16'h002c);
    dma(1'b1, d);
    chk(tx_word, d);
    chk({7'h00, irqv}, 16'h0000);
    spsi_link_model_inst.tx_frame();
    idle(8);
    rd(A_ST, 32'h2, OK);
    chk({7'h00, irqv}, 16'h002c);
    spsi_link_model_inst.tx_frame();
    idle(8);
    rd(A_ST, 32'ha, OK);
    chk({7'h00, irqv}, 16'h00aa);
    wr(A_ST, 32'h0, OK);
    rd(A_ST, 32'h0, OK);
    chk({7'h00, irqv}, 16'h0000);
    spsi_link_model_inst.rx_frame(w1);
    idle(8);
    rd(A_ST, 32'h1, OK);
    chk(rx_data, w1);
    chk({7'h00, irqv}, 16'h0053);
    spsi_link_model_inst.rx_frame(w2);
    idle(8);
    rd(A_ST, 32'h5, OK);
    chk(rx_data, w2);
    chk({7'h00, irqv}, 16'h0151);
    wr(A_ST, 32'h1, OK);
    rd(A_ST, 32'h1, OK);
    chk({7'h00, irqv}, 16'h0053);
    wr(A_CT, 32'h3, OK);
    chk({7'h00, irqv}, 16'h0000);
    wr(A_CT, 32'hf, OK);
    dma(1'b0, 16'h0000);
    rd(A_ST, 32'h0, OK);
    spsi_link_model_inst.rx_frame(w1);
    idle(8);
    rd(A_ST, 32'h1, OK);
    wr(A_ST, 32'h0, OK);
    rd(A_ST, 32'h0, OK);
    spsi_link_model_inst.rx_frame(w2);
    idle(8);
    wr(A_CT, 32'he, OK);
    rd(A_ST, 32'h0, OK);
    wr(A_CT, 32'h0, OK);
    rd(A_ST, 32'h2, OK);
    final_report();
  end
endmodule : spsi_top_test
